// [hdl/sto_pkg.sv]
// package: constants and types for the torque-off monitor
package sto_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int SKEW_MS = 1000;
  localparam int SKEW_CYCLES = (CLK_HZ / 1000) * SKEW_MS;
  localparam int CNT_W = 25;
  typedef enum logic [1:0] {
    STO_IDLE = 2'b00,
    STO_RUN = 2'b01,
    STO_SHUT = 2'b11,
    STO_DISC = 2'b10
  } sto_state_e;
endpackage

// [hdl/sto_if.sv]
// interface: synchronised channel levels from the input stage
`timescale 1ns/1ps
interface sto_chan_if;
  logic chanA;
  logic chanB;
  modport src (output chanA, output chanB);
  modport dst (input chanA, input chanB);
endinterface

// [hdl/sto_sync.sv]
// two-flop synchronisers for both safety channel pins
`timescale 1ns/1ps
module sto_sync (
  input wire logic core_clk,
  input wire logic rst,
  // pins
  input wire logic chanAPin,
  input wire logic chanBPin,
  // synchronised
  sto_chan_if.src outp
);
  logic [1:0] stgA;
  logic [1:0] stgB;
  logic [1:0] next_stgA;
  logic [1:0] next_stgB;
  always_comb begin
    next_stgA = {stgA[0], chanAPin};
    next_stgB = {stgB[0], chanBPin};
  end
  // reset low: channels read as removed until proven high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stgA <= 2'h0;
      stgB <= 2'h0;
    end else begin
      stgA <= next_stgA;
      stgB <= next_stgB;
    end
  end
  assign outp.chanA = stgA[1];
  assign outp.chanB = stgB[1];
endmodule

// [hdl/sto_monitor.sv]
// top: dual-channel safe torque-off monitor
// How it works
// - torque removed when both active-low channels low, each channel treated independently
// - valid dual shutdown disables amplifier and raises fault; motor coasts
// - after dual shutdown, no re-enable until fault reset clears the fault
// - only one channel low also disables amplifier, raises discrepancy fault once it outlasts the skew window
// - discrepancy fault ignores fault reset; only power-on reset clears it
// - no standstill supervision after torque removal
// - controlled stop from halt pin or fieldbus; standstill not supervised
// - after power-up the drive waits for an explicit enable command
`timescale 1ns/1ps
module sto_monitor
  import sto_pkg::*;
#(
  parameter int SKEW_LIMIT = SKEW_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // safety channels, active low removal
  input wire logic safety_disable_chan_a_n,
  input wire logic safety_disable_chan_b_n,
  // commands from the drive controller
  input wire logic haltPin,
  input wire logic fieldbusHalt,
  input wire logic enableCmd,
  input wire logic faultReset,
  // drive outputs
  output logic ampEnable,
  output logic haltRequest,
  output logic shutdownFault,
  output logic discrepancyFault
);
  // the counter must hold the window and the compare must be reachable
  if (SKEW_LIMIT < 2 || SKEW_LIMIT >= (1 << CNT_W)) begin : g_bad_skew
    $error("SKEW_LIMIT out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  sto_chan_if chan ();
  logic haltSync0;
  logic haltSync1;
  logic next_haltSync0;
  logic next_haltSync1;

  sto_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .chanAPin(safety_disable_chan_a_n),
    .chanBPin(safety_disable_chan_b_n),
    .outp(chan.src)
  );

  // halt is a pin too, so it gets two flops
  always_comb begin
    next_haltSync0 = haltPin;
    next_haltSync1 = haltSync0;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      haltSync0 <= 1'b0;
      haltSync1 <= 1'b0;
    end else begin
      haltSync0 <= next_haltSync0;
      haltSync1 <= next_haltSync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sto_state_e state;
  sto_state_e next_state;
  logic [CNT_W-1:0] skewCnt;
  logic [CNT_W-1:0] next_skewCnt;
  logic haltReq;
  logic next_haltReq;
  logic bothLow;
  logic oneLow;
  logic bothHigh;
  logic skewOut;

  assign bothLow = !chan.chanA && !chan.chanB;
  assign bothHigh = chan.chanA && chan.chanB;
  assign oneLow = chan.chanA ^ chan.chanB;
  assign skewOut = (skewCnt >= CNT_W'(SKEW_LIMIT - 1));

  always_comb begin
    next_state = state;
    next_skewCnt = '0;
    // controlled stop only asks the loop to decelerate; no standstill
    next_haltReq = haltSync1 || fieldbusHalt;
    if (oneLow) begin
      // count how long the channels disagree; partner keeps it under 1 s
      next_skewCnt = skewOut ? skewCnt : skewCnt + CNT_W'(1);
    end
    case (state)
      STO_IDLE: begin
        // power-up waits for an explicit enable, never self-starts
        if (bothHigh && enableCmd) begin
          next_state = STO_RUN;
        end
      end
      STO_RUN: begin
        if (bothLow) begin
          next_state = STO_SHUT;
        end else if (oneLow) begin
          // a lone drop may be the first half of a skewed dual drop
          next_state = STO_SHUT; // amplifier off now, discrepancy once skew runs out
        end
      end
      STO_SHUT: begin
        // skew beyond limit while shut turns into discrepancy
        if (oneLow && skewOut) begin
          next_state = STO_DISC;
        end else if (faultReset && bothHigh) begin
          // reset leads to idle, then a fresh enable is needed
          next_state = STO_IDLE;
        end
      end
      STO_DISC: begin
        next_state = STO_DISC; // only rst leaves here
      end
      default: begin
        next_state = STO_SHUT;
      end
    endcase
    // a lone drop in idle still latches discrepancy once skew expires
    if (state == STO_IDLE && oneLow && skewOut) begin
      next_state = STO_DISC;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= STO_IDLE;
      skewCnt <= '0;
      haltReq <= 1'b0;
    end else begin
      state <= next_state;
      skewCnt <= next_skewCnt;
      haltReq <= next_haltReq;
    end
  end

  // amplifier only while running; both fault states keep it off
  assign ampEnable = (state == STO_RUN);
  assign shutdownFault = (state == STO_SHUT);
  assign discrepancyFault = (state == STO_DISC);
  assign haltRequest = haltReq;

  ////////////////////////////////////////////////////////////////////////////
  // checker helper: disagreement cycles, counted apart from skewCnt
  // saturates so a stuck channel never wraps back into the window
  logic [CNT_W-1:0] lagCnt;
  logic [CNT_W-1:0] next_lagCnt;
  always_comb begin
    next_lagCnt = '0;
    if (oneLow && lagCnt != '1) begin
      next_lagCnt = lagCnt + CNT_W'(1);
    end else if (oneLow) begin
      next_lagCnt = lagCnt;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lagCnt <= '0;
    end else begin
      lagCnt <= next_lagCnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_dual_drop_off: assert property (@(posedge core_clk) disable iff (rst)
    (state == STO_RUN && bothLow) |=> (shutdownFault && !ampEnable))
    else $error("dual drop did not latch shutdown");
  chk_single_drop: assert property (@(posedge core_clk) disable iff (rst)
    (state == STO_RUN && oneLow) |=> (shutdownFault && !ampEnable))
    else $error("single drop did not stop the amplifier");
  chk_disc_sticky: assert property (@(posedge core_clk) disable iff (rst)
    discrepancyFault |=> discrepancyFault [*8])
    else $error("discrepancy fault cleared without reset");
  chk_no_reenable: assert property (@(posedge core_clk) disable iff (rst)
    (shutdownFault && !faultReset) |=> !ampEnable)
    else $error("amplifier re-enabled without fault reset");
  chk_reset_clear: assert property (@(posedge core_clk) disable iff (rst)
    (shutdownFault && faultReset && bothHigh && !oneLow) |=> (!shutdownFault && !ampEnable)
    ##1 (!ampEnable || $past(enableCmd)))
    else $error("fault reset mishandled");
  chk_enable_explicit: assert property (@(posedge core_clk) disable iff (rst)
    $rose(ampEnable) |-> $past(enableCmd) && $past(state) == STO_IDLE)
    else $error("amplifier started without enable");
  chk_faults_exclusive: assert property (@(posedge core_clk) disable iff (rst)
    !(ampEnable && (shutdownFault || discrepancyFault)) && !(shutdownFault && discrepancyFault))
    else $error("fault states overlap");
  chk_halt_path: assert property (@(posedge core_clk) disable iff (rst)
    fieldbusHalt |=> haltRequest)
    else $error("fieldbus halt not forwarded");
  chk_drop_off: assert property (@(posedge core_clk) disable iff (rst)
    (!chan.chanA || !chan.chanB) |=> !ampEnable)
    else $error("amplifier on with a channel removed");
  chk_lag_window: assert property (@(posedge core_clk) disable iff (rst)
    (!discrepancyFault && lagCnt < CNT_W'(SKEW_LIMIT - 1)) |=> !discrepancyFault)
    else $error("discrepancy latched inside the skew window");
  chk_lag_latch: assert property (@(posedge core_clk) disable iff (rst)
    (oneLow && lagCnt >= CNT_W'(SKEW_LIMIT - 1)) |=> discrepancyFault)
    else $error("lone channel outlived the skew window unlatched");
  chk_dual_no_disc: assert property (@(posedge core_clk) disable iff (rst)
    (bothLow && !discrepancyFault) |=> !discrepancyFault)
    else $error("dual drop raised discrepancy");
  chk_shut_hold: assert property (@(posedge core_clk) disable iff (rst)
    (shutdownFault && !faultReset && !(oneLow && skewOut)) |=> shutdownFault)
    else $error("shutdown fault cleared without fault reset");
  chk_halt_pin: assert property (@(posedge core_clk) disable iff (rst)
    haltPin [*3] |=> haltRequest)
    else $error("halt pin not forwarded");
  chk_idle_hold: assert property (@(posedge core_clk) disable iff (rst)
    (state == STO_IDLE && !enableCmd) |=> !ampEnable)
    else $error("amplifier started from idle without enable");
  chk_enable_refused: assert property (@(posedge core_clk) disable iff (rst)
    (state == STO_IDLE && !bothHigh) |=> !ampEnable)
    else $error("amplifier started with a channel removed");
endmodule

// [tb/sto_estop_model.sv]
// emergency stop module model driving both channels and the halt pin
`timescale 1ns/1ps
module sto_estop_model #(
  parameter int DELAY = 6
) (
  // clock
  input wire logic core_clk,
  // bench commands
  input wire logic trip,
  input wire logic tripOne,
  input wire logic stopCat1,
  // drive pins
  output logic chanA_n,
  output logic chanB_n,
  output logic haltOut
);
  int cnt = 0;
  // one contact feeds both channels, so zero skew
  assign chanB_n = !(trip || cnt >= DELAY);
  // channel a alone: a lagging contact or a broken wire
  assign chanA_n = chanB_n && !tripOne;
  // halt first, channels drop after the delay; never a restart
  assign haltOut = stopCat1;
  always @(posedge core_clk) begin
    if (!stopCat1) begin
      cnt <= 0;
    end else if (cnt < DELAY) begin
      cnt <= cnt + 1;
    end
  end
endmodule

// [tb/sto_monitor_tb.sv]
// testbench for the torque-off monitor
`timescale 1ns/1ps
module sto_monitor_tb;
  import sto_pkg::*;
  logic core_clk = 0, rst = 1, fieldbusHalt = 0, enableCmd = 0, faultReset = 0;
  logic trip = 0, tripOne = 0, stopCat1 = 0;
  logic chanA_n, chanB_n, haltOut, ampEnable, haltRequest, shutdownFault, discrepancyFault;
  int failures = 0, n_tests = 0;
  always #20 core_clk = ~core_clk;
  sto_estop_model #(.DELAY(6)) PM (.core_clk(core_clk), .trip(trip), .tripOne(tripOne),
    .stopCat1(stopCat1), .chanA_n(chanA_n), .chanB_n(chanB_n), .haltOut(haltOut));
  // short skew window keeps the run brief
  localparam int SKEW = 16;
  sto_monitor #(.SKEW_LIMIT(SKEW)) DUT (.core_clk(core_clk), .rst(rst),
    .safety_disable_chan_a_n(chanA_n), .safety_disable_chan_b_n(chanB_n),
    .haltPin(haltOut), .fieldbusHalt(fieldbusHalt), .enableCmd(enableCmd),
    .faultReset(faultReset), .ampEnable(ampEnable), .haltRequest(haltRequest),
    .shutdownFault(shutdownFault), .discrepancyFault(discrepancyFault));
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic do_reset;
    rst = 1;
    step(4);
    rst = 0;
  endtask
  task automatic reset_and_enable;
    faultReset = 1;
    step(1);
    faultReset = 0;
    enableCmd = 1;
    step(2);
    enableCmd = 0;
  endtask
  task automatic t_power;
    step(1);
    do_reset;
    step(8);
    chk("ampEnable", 1'b0, ampEnable);
    enableCmd = 1;
    step(4);
    enableCmd = 0;
    chk("ampEnable", 1'b1, ampEnable);
    $display("t_power done");
  endtask
  task automatic t_dual;
    trip = 1;
    step(4);
    chk("ampEnable", 1'b0, ampEnable);
    chk("shutdownFault", 1'b1, shutdownFault);
    chk("discrepancyFault", 1'b0, discrepancyFault);
    trip = 0;
    step(3);
    enableCmd = 1;
    step(2);
    enableCmd = 0;
    chk("ampEnable", 1'b0, ampEnable);
    reset_and_enable;
    chk("shutdownFault", 1'b0, shutdownFault);
    chk("ampEnable", 1'b1, ampEnable);
    $display("t_dual done");
  endtask
  task automatic t_halt;
    fieldbusHalt = 1;
    step(1);
    chk("haltRequest", 1'b1, haltRequest);
    fieldbusHalt = 0;
    step(1);
    chk("haltRequest", 1'b0, haltRequest);
    stopCat1 = 1;
    step(4);
    chk("haltRequest", 1'b1, haltRequest);
    chk("ampEnable", 1'b1, ampEnable);
    step(8);
    chk("shutdownFault", 1'b1, shutdownFault);
    stopCat1 = 0;
    step(3);
    reset_and_enable;
    chk("ampEnable", 1'b1, ampEnable);
    $display("t_halt done");
  endtask
  task automatic t_skew;
    tripOne = 1;
    step(4);
    trip = 1;
    step(4);
    chk("ampEnable", 1'b0, ampEnable);
    chk("shutdownFault", 1'b1, shutdownFault);
    chk("discrepancyFault", 1'b0, discrepancyFault);
    trip = 0;
    step(6);
    tripOne = 0;
    step(3);
    chk("discrepancyFault", 1'b0, discrepancyFault);
    reset_and_enable;
    chk("ampEnable", 1'b1, ampEnable);
    $display("t_skew done");
  endtask
  task automatic t_disc;
    tripOne = 1;
    step(4);
    chk("ampEnable", 1'b0, ampEnable);
    chk("shutdownFault", 1'b1, shutdownFault);
    chk("discrepancyFault", 1'b0, discrepancyFault);
    step(SKEW - 3);
    chk("discrepancyFault", 1'b0, discrepancyFault);
    step(1);
    chk("discrepancyFault", 1'b1, discrepancyFault);
    chk("shutdownFault", 1'b0, shutdownFault);
    tripOne = 0;
    step(3);
    reset_and_enable;
    chk("discrepancyFault", 1'b1, discrepancyFault);
    chk("ampEnable", 1'b0, ampEnable);
    do_reset;
    chk("discrepancyFault", 1'b0, discrepancyFault);
    // lone channel at idle latches once the window runs out
    tripOne = 1;
    step(SKEW + 2);
    chk("discrepancyFault", 1'b1, discrepancyFault);
    chk("ampEnable", 1'b0, ampEnable);
    tripOne = 0;
    $display("t_disc done");
  endtask
  initial begin
    #20000;
    failures++;
    end_sim;
  end
  initial begin
    t_power;
    t_dual;
    t_halt;
    t_skew;
    t_disc;
    end_sim;
  end
endmodule
